/* File: hw/sesl_pkg.sv */
package sesl_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned IO_AW = 16;
  localparam int unsigned DW = 8;
  localparam int unsigned NUM_SRC = 6;

  // ****************************************************************
  // offsets inside the two system i/o windows
  // ****************************************************************
  localparam logic [IO_AW-1:0] OFS_PM_TIMER_TOP = 16'h000b;
  localparam logic [IO_AW-1:0] OFS_EVT0_STATUS_LOW = 16'h0000;
  localparam logic [IO_AW-1:0] OFS_EVT0_STATUS_HIGH = 16'h0001;
  localparam logic [IO_AW-1:0] OFS_EVT0_ENABLE_LOW = 16'h0002;
  localparam logic [IO_AW-1:0] OFS_EVT0_ENABLE_HIGH = 16'h0003;

  // ****************************************************************
  // reset values and fixed read values
  // ****************************************************************
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
  localparam logic [NUM_SRC-1:0] RST_SRC = 6'h00;
  localparam logic [DW-NUM_SRC-1:0] RSVD_BITS = 2'h0;

  // ****************************************************************
  // source bit positions
  // ****************************************************************
  localparam int unsigned BIT_SERIAL_PORT_TWO = 0;
  localparam int unsigned BIT_SERIAL_PORT_ONE = 1;
  localparam int unsigned BIT_FLOPPY_CTRL = 2;
  localparam int unsigned BIT_PRINTER_PORT = 3;
  localparam int unsigned BIT_KEYBOARD_CTRL = 4;
  localparam int unsigned BIT_POINTER_DEVICE = 5;

endpackage

/* File: hw/sesl_event_flag.sv */
`timescale 1ns/1ps
// one sticky event flag: set on a rising request, cleared by software
module sesl_event_flag (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic irq,
  input wire logic clear,
  output logic flag
);

  logic irq_prev_reg;
  logic flag_reg;
  logic flag_next;
  wire irq_rise = irq & ~irq_prev_reg;

  // clear has priority: a request in the clearing cycle counts as arriving while set
  assign flag_next = clear ? 1'b0 : (flag_reg | irq_rise);
  assign flag = flag_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_prev_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      irq_prev_reg <= irq;
      flag_reg <= flag_next;
    end
  end

endmodule // sesl_event_flag

/* File: hw/sesl_top.sv */
`timescale 1ns/1ps
// Behaviour
// - upper timer byte at power-management offset b always reads zero, default zero.
// - a raised peripheral request sets its status bit until software clears it, unless a clear of that bit is taken at the same edge.
// - set status with matching enable set drives active-low sci output.
// - writing 1 to a status bit clears it; bits written 0 unchanged.
// - writing 0 to any status bit has no effect.
// - while a status bit is set, further requests from that source are ignored.
// - bits 0-5 are serial two, serial one, floppy, printer, keyboard, pointer; 6-7 reserved.
// - sci is the or over six sources of enable and status.
module sesl_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] pm_base,
  input wire logic [15:0] evt_base,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic serial_port_two_irq,
  input wire logic serial_port_one_irq,
  input wire logic floppy_ctrl_irq,
  input wire logic printer_port_irq,
  input wire logic keyboard_ctrl_irq,
  input wire logic pointer_device_irq,
  output logic sci_n
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_timer_top = (io_addr == pm_base + sesl_pkg::OFS_PM_TIMER_TOP);
  wire hit_status_low = (io_addr == evt_base + sesl_pkg::OFS_EVT0_STATUS_LOW);
  wire hit_status_high = (io_addr == evt_base + sesl_pkg::OFS_EVT0_STATUS_HIGH);
  wire hit_enable_low = (io_addr == evt_base + sesl_pkg::OFS_EVT0_ENABLE_LOW);
  wire hit_enable_high = (io_addr == evt_base + sesl_pkg::OFS_EVT0_ENABLE_HIGH);

  wire status_wr = io_wr & hit_status_low;
  wire enable_wr = io_wr & hit_enable_low;

  // ****************************************************************
  // sources and flags
  // ****************************************************************
  logic [sesl_pkg::NUM_SRC-1:0] irq_vec;
  logic [sesl_pkg::NUM_SRC-1:0] flag_vec;
  logic [sesl_pkg::NUM_SRC-1:0] clear_vec;
  logic [sesl_pkg::NUM_SRC-1:0] enable_reg;
  logic [7:0] io_rdata_reg;
  logic [7:0] rdata_next;

  assign irq_vec[sesl_pkg::BIT_SERIAL_PORT_TWO] = serial_port_two_irq;
  assign irq_vec[sesl_pkg::BIT_SERIAL_PORT_ONE] = serial_port_one_irq;
  assign irq_vec[sesl_pkg::BIT_FLOPPY_CTRL] = floppy_ctrl_irq;
  assign irq_vec[sesl_pkg::BIT_PRINTER_PORT] = printer_port_irq;
  assign irq_vec[sesl_pkg::BIT_KEYBOARD_CTRL] = keyboard_ctrl_irq;
  assign irq_vec[sesl_pkg::BIT_POINTER_DEVICE] = pointer_device_irq;

  // zero bits in the written byte leave their flags alone
  assign clear_vec = status_wr ? io_wdata[sesl_pkg::NUM_SRC-1:0] : sesl_pkg::RST_SRC;

  for (genvar i = 0; i < sesl_pkg::NUM_SRC; i++) begin : g_src
    sesl_event_flag u_flag (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .irq(irq_vec[i]),
      .clear(clear_vec[i]),
      .flag(flag_vec[i])
    );
  end

  // ****************************************************************
  // enable register and sci output
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= sesl_pkg::RST_SRC;
    end else if (enable_wr) begin
      enable_reg <= io_wdata[sesl_pkg::NUM_SRC-1:0];
    end
  end

  // all state feeding this is registered, so the pin is glitch free
  assign sci_n = ~|(enable_reg & flag_vec);

  // ****************************************************************
  // read path
  // ****************************************************************
  // reserved bytes and unmapped addresses answer zero
  assign rdata_next = hit_status_low ? {sesl_pkg::RSVD_BITS, flag_vec} :
                      hit_enable_low ? {sesl_pkg::RSVD_BITS, enable_reg} :
                      (hit_timer_top | hit_status_high | hit_enable_high) ? sesl_pkg::ZERO_BYTE :
                      sesl_pkg::ZERO_BYTE;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata_reg <= sesl_pkg::RST_BYTE;
    end else if (io_rd) begin
      io_rdata_reg <= rdata_next;
    end
  end

  assign io_rdata = io_rdata_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [sesl_pkg::NUM_SRC-1:0] irq_prev_chk;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_prev_chk <= sesl_pkg::RST_SRC;
    end else begin
      irq_prev_chk <= irq_vec;
    end
  end
  wire [sesl_pkg::NUM_SRC-1:0] rise_chk = irq_vec & ~irq_prev_chk;

  property p_timer_top_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (io_rd && hit_timer_top) |=> (io_rdata == sesl_pkg::ZERO_BYTE);
  endproperty
  a_timer_top_zero: assert property (p_timer_top_zero) else $error("timer top byte not zero");

  property p_flag_sets;
    @(posedge ref_clk) disable iff (!rstn)
    (rise_chk[sesl_pkg::BIT_SERIAL_PORT_TWO] && !clear_vec[sesl_pkg::BIT_SERIAL_PORT_TWO])
      |=> flag_vec[sesl_pkg::BIT_SERIAL_PORT_TWO];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("request did not set flag");

  // the flag must hold on its own, whatever the request line does meanwhile
  property p_flag_sticky;
    @(posedge ref_clk) disable iff (!rstn)
    (flag_vec[sesl_pkg::BIT_PRINTER_PORT] && !clear_vec[sesl_pkg::BIT_PRINTER_PORT])
      |=> flag_vec[sesl_pkg::BIT_PRINTER_PORT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear");

  sequence s_enable_on_set_flag;
    enable_wr && io_wdata[sesl_pkg::BIT_SERIAL_PORT_ONE] && flag_vec[sesl_pkg::BIT_SERIAL_PORT_ONE]
      && !clear_vec[sesl_pkg::BIT_SERIAL_PORT_ONE];
  endsequence
  property p_sci_raised;
    @(posedge ref_clk) disable iff (!rstn)
    s_enable_on_set_flag |=> !sci_n;
  endproperty
  a_sci_raised: assert property (p_sci_raised) else $error("sci not raised for enabled flag");

  property p_sci_needs_enable;
    @(posedge ref_clk) disable iff (!rstn)
    (enable_reg == sesl_pkg::RST_SRC) |-> sci_n;
  endproperty
  a_sci_needs_enable: assert property (p_sci_needs_enable) else $error("sci low with no enable set");

  property p_w1c;
    @(posedge ref_clk) disable iff (!rstn)
    (status_wr && io_wdata[sesl_pkg::BIT_FLOPPY_CTRL]) |=> !flag_vec[sesl_pkg::BIT_FLOPPY_CTRL];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_write_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (status_wr && !io_wdata[sesl_pkg::BIT_PRINTER_PORT] && flag_vec[sesl_pkg::BIT_PRINTER_PORT])
      |=> flag_vec[sesl_pkg::BIT_PRINTER_PORT];
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write zero changed flag");

  // a level left high after its flag was taken must not set the flag again
  property p_set_needs_edge;
    @(posedge ref_clk) disable iff (!rstn)
    !flag_vec[sesl_pkg::BIT_KEYBOARD_CTRL] ##1 flag_vec[sesl_pkg::BIT_KEYBOARD_CTRL]
      |-> $past(rise_chk[sesl_pkg::BIT_KEYBOARD_CTRL]);
  endproperty
  a_set_needs_edge: assert property (p_set_needs_edge) else $error("flag set without request edge");

  // a request ignored while set is not queued: a lone clear leaves the flag clear
  sequence s_kbd_lone_clear;
    flag_vec[sesl_pkg::BIT_KEYBOARD_CTRL] && clear_vec[sesl_pkg::BIT_KEYBOARD_CTRL]
      && !rise_chk[sesl_pkg::BIT_KEYBOARD_CTRL];
  endsequence
  property p_ignore_while_set;
    @(posedge ref_clk) disable iff (!rstn)
    s_kbd_lone_clear |=> !flag_vec[sesl_pkg::BIT_KEYBOARD_CTRL];
  endproperty
  a_ignore_while_set: assert property (p_ignore_while_set) else $error("ignored request was kept");

  sequence s_pointer_request;
    pointer_device_irq && !irq_prev_chk[sesl_pkg::BIT_POINTER_DEVICE] && !status_wr;
  endsequence
  sequence s_status_read;
    io_rd && hit_status_low && !status_wr;
  endsequence
  property p_bit_order;
    @(posedge ref_clk) disable iff (!rstn)
    s_pointer_request ##1 s_status_read
      |=> (io_rdata[sesl_pkg::BIT_POINTER_DEVICE] && io_rdata[sesl_pkg::DW-1:sesl_pkg::NUM_SRC] == sesl_pkg::RSVD_BITS);
  endproperty
  a_bit_order: assert property (p_bit_order) else $error("pointer flag not at bit five");

  property p_enable_reserved_zero;
    @(posedge ref_clk) disable iff (!rstn)
    (io_rd && hit_enable_low) |=> (io_rdata[sesl_pkg::DW-1:sesl_pkg::NUM_SRC] == sesl_pkg::RSVD_BITS);
  endproperty
  a_enable_reserved_zero: assert property (p_enable_reserved_zero) else $error("reserved enable bits not zero");

  property p_sci_release;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(sci_n) |-> $past(status_wr || enable_wr);
  endproperty
  a_sci_release: assert property (p_sci_release) else $error("sci released without software access");

  property p_sci_any_source;
    @(posedge ref_clk) disable iff (!rstn)
    (enable_reg[sesl_pkg::BIT_POINTER_DEVICE] && flag_vec[sesl_pkg::BIT_POINTER_DEVICE]) |-> !sci_n;
  endproperty
  a_sci_any_source: assert property (p_sci_any_source) else $error("enabled pointer flag left sci high");

  property p_clear_wins;
    @(posedge ref_clk) disable iff (!rstn)
    (clear_vec[sesl_pkg::BIT_FLOPPY_CTRL] && rise_chk[sesl_pkg::BIT_FLOPPY_CTRL]) ##1
      !rise_chk[sesl_pkg::BIT_FLOPPY_CTRL] |-> !flag_vec[sesl_pkg::BIT_FLOPPY_CTRL];
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("request in clear cycle was kept");

endmodule // sesl_top

/* File: dv/sesl_periph_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// peripheral request sources
// ****************************************************************
// request levels change off the sampling edge; a level held high is one event only
module sesl_periph_model (
  input wire logic ref_clk,
  input wire logic [5:0] req,
  output logic [5:0] irq
);
  initial irq = 6'h00;
  always @(negedge ref_clk) begin
    irq <= req;
  end
endmodule // sesl_periph_model

/* File: dv/sesl_top_tb.sv */
`timescale 1ns/1ps
module sesl_top_tb;
  localparam logic [15:0] PM = 16'h0400;
  localparam logic [15:0] EV = 16'h0480;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic [5:0] req = 6'h00;
  logic [5:0] irq;
  logic sci_n;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [5:0] en;
  logic [5:0] st;
  logic [7:0] m;
  always #5 ref_clk = ~ref_clk;
  sesl_periph_model periph_u (.ref_clk(ref_clk), .req(req), .irq(irq));
  sesl_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .pm_base(PM), .evt_base(EV), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .serial_port_two_irq(irq[sesl_pkg::BIT_SERIAL_PORT_TWO]), .serial_port_one_irq(irq[sesl_pkg::BIT_SERIAL_PORT_ONE]),
    .floppy_ctrl_irq(irq[sesl_pkg::BIT_FLOPPY_CTRL]), .printer_port_irq(irq[sesl_pkg::BIT_PRINTER_PORT]),
    .keyboard_ctrl_irq(irq[sesl_pkg::BIT_KEYBOARD_CTRL]), .pointer_device_irq(irq[sesl_pkg::BIT_POINTER_DEVICE]),
    .sci_n(sci_n));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_sci(input logic [5:0] e, input logic [5:0] s);
    cmp8({7'h00, sci_n}, {7'h00, ~|(e & s)});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic io_read(input logic [15:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    io_rd <= 1'b0;
  endtask
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(negedge ref_clk);
    io_wr <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // read data lands on the edge that takes the read, so look just after it
  always @(posedge ref_clk) begin
    if (io_rd === 1'b1 && rstn === 1'b1) begin
      #1;
      cmp8(io_rdata, exp_q.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'hd231));
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn <= 1'b1;
    io_read(PM + 16'h000b, 8'h00);
    io_read(EV, 8'h00);
    io_read(EV + 16'h0002, 8'h00);
    io_read(EV + 16'h0001, 8'h00);
    io_read(EV + 16'h0003, 8'h00);
    io_read(EV + 16'h0010, 8'h00);
    cmp_sci(6'h00, 6'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      req <= 6'h01 << i;
      // read in the cycle right after the request edge, so the pin-to-bit check fires
      tick(1);
      io_read(EV, 8'h01 << i);
      cmp_sci(6'h00, 6'h3f);
      io_write(EV + 16'h0002, 8'h01 << i);
      cmp_sci(6'h01 << i, 6'h01 << i);
      io_write(EV, ~(8'h01 << i));
      io_read(EV, 8'h01 << i);
      req <= 6'h00;
      tick(2);
      req <= 6'h01 << i;
      tick(3);
      io_write(EV, 8'h01 << i);
      io_read(EV, 8'h00);
      cmp_sci(6'h01 << i, 6'h00);
      req <= 6'h00;
      io_write(EV + 16'h0002, 8'h00);
    end
    $display("test per source done");
    for (int k = 0; k < 8; k++) begin
      en = 6'($urandom);
      st = 6'($urandom);
      m = 8'($urandom);
      io_write(EV + 16'h0002, {2'h0, en});
      req <= st;
      tick(3);
      io_read(EV + 16'h0002, {2'h0, en});
      io_read(EV, {2'h0, st});
      cmp_sci(en, st);
      io_write(PM + 16'h000b, m);
      io_write(EV + 16'h0001, m);
      io_read(EV + 16'h0001, 8'h00);
      io_read(PM + 16'h000b, 8'h00);
      io_write(EV, m);
      io_read(EV, {2'h0, st & ~m[5:0]});
      io_write(EV, 8'h3f);
      req <= 6'h00;
      tick(2);
    end
    $display("test random done");
    // request rise and clearing write taken at the same edge
    req <= 6'h04;
    tick(3);
    req <= 6'h00;
    tick(2);
    req <= 6'h04;
    io_write(EV, 8'h04);
    io_read(EV, 8'h00);
    $display("test clear collision done");
    report_and_stop();
  end
endmodule // sesl_top_tb
